// ===== rtl/osc_ctrl_pkg.sv
// Package for the oscillator select and clock divider control block.
// Assumes a 32-bit APB slave on pclk with byte addresses word aligned.
package osc_ctrl_pkg;

	// ==========================================================
	// Register map (index form, byte address = 4 * (index - 0x100))
	localparam logic [11:0] osc_ctrl_idx = 12'h100;
	localparam logic [11:0] clk_div_idx = 12'h102;
	localparam logic [11:0] unlock_idx = 12'h104;
	localparam logic [11:0] irq_status_idx = 12'h108;
	localparam logic [11:0] irq_mask_idx = 12'h10c;
	localparam logic [11:0] pll_timer_idx = 12'h110;
	localparam logic [7:0] osc_ctrl_addr = 8'h00;
	localparam logic [7:0] clk_div_addr = 8'h08;
	localparam logic [7:0] unlock_addr = 8'h10;
	localparam logic [7:0] irq_status_addr = 8'h20;
	localparam logic [7:0] irq_mask_addr = 8'h30;
	localparam logic [7:0] pll_timer_addr = 8'h40;

	// ==========================================================
	// Field positions
	localparam int cur_src_lsb = 12;
	localparam int next_src_lsb = 8;
	localparam int sel_freeze_bit = 7;
	localparam int pin_freeze_bit = 6;
	localparam int pll_settled_bit = 5;
	localparam int fail_bit = 3;
	localparam int prim_keep_bit = 2;
	localparam int sec_on_bit = 1;
	localparam int switch_bit = 0;
	localparam int recover_bit = 15;
	localparam int ratio_lsb = 12;
	localparam int ratio_apply_bit = 11;
	localparam int div_src_lsb = 8;
	localparam int postscale_lsb = 6;
	localparam int pll_keep_bit = 5;

	// ==========================================================
	// Reset values and keys
	localparam logic [2:0] ratio_reset = 3'h3;
	localparam logic [1:0] postscale_reset = 2'h0;
	localparam logic pll_keep_reset = 1'b1;
	localparam logic [15:0] unlock_key1 = 16'h0057;
	localparam logic [15:0] unlock_key2 = 16'h00aa;

	// ==========================================================
	// Timing: PLL start-up wait and switch settle time
	localparam int clk_period_ps = 25000;
	localparam int pll_start_ns = 2000;
	localparam int pll_start_cycles = (pll_start_ns * 1000 + clk_period_ps - 1)
		/ clk_period_ps;
	localparam int switch_ns = 100;
	localparam int switch_cycles = (switch_ns * 1000 + clk_period_ps - 1)
		/ clk_period_ps;

	// Interrupt status bit positions
	localparam int ev_switch_done = 0;
	localparam int ev_fail = 1;
	localparam int ev_pll_settled = 2;

	// ==========================================================
	// Source codes
	typedef enum logic [2:0] {
		src_fast_rc = 3'h0,
		src_fast_rc_pll = 3'h1,
		src_primary = 3'h2,
		src_primary_pll = 3'h3,
		src_secondary = 3'h4,
		src_low_power_rc = 3'h5,
		src_reserved = 3'h6,
		src_divided = 3'h7
	} source_type;

	// Configuration straps
	typedef struct packed {
		logic [2:0] boot_source_cfg;
		logic [1:0] fail_monitor_cfg;
		logic one_way_pin_freeze;
	} config_type;

	// Oscillator and clock steering outputs
	typedef struct packed {
		logic [2:0] active_source;
		logic [2:0] divider_source;
		logic [7:0] cpu_ratio;
		logic [3:0] pll_postscale;
		logic primary_run;
		logic secondary_run;
		logic pll_run;
	} clock_steer_type;

	// Active source is a PLL mode
	function automatic logic is_pll_src(input logic [2:0] s);
		return (s == src_fast_rc_pll) || (s == src_primary_pll);
	endfunction

endpackage

// ===== rtl/osc_select_divider.sv
// Oscillator source selection, doze ratio and PLL postscale control.
// Assumes straps stable around reset; status pins from other clocks.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module osc_select_divider
	import osc_ctrl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire config_type straps,
	input wire logic pll_locked_pin,
	input wire logic clock_fail_pin,
	input wire logic sleep_req,
	input wire logic cpu_irq,
	output clock_steer_type steer,
	output logic pin_config_freeze,
	output logic irq
);

	// ==========================================================
	// Input synchronisers
	logic [1:0] lock_sync_r;
	logic [1:0] fail_sync_r;
	logic [1:0] sleep_sync_r;
	logic [1:0] cpuirq_sync_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_sync_r <= 2'h0;
			fail_sync_r <= 2'h0;
			sleep_sync_r <= 2'h0;
			cpuirq_sync_r <= 2'h0;
		end else begin
			lock_sync_r <= {lock_sync_r[0], pll_locked_pin};
			fail_sync_r <= {fail_sync_r[0], clock_fail_pin};
			sleep_sync_r <= {sleep_sync_r[0], sleep_req};
			cpuirq_sync_r <= {cpuirq_sync_r[0], cpu_irq};
		end
	end
	wire pll_locked = lock_sync_r[1];
	wire clk_fail = fail_sync_r[1];
	wire in_sleep = sleep_sync_r[1];
	wire irq_seen = cpuirq_sync_r[1];

	// ==========================================================
	// Bus decode; single-cycle access, every write takes at access phase
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire wr_osc = wr && (paddr == osc_ctrl_addr);
	wire wr_div = wr && (paddr == clk_div_addr);
	wire wr_unl = wr && (paddr == unlock_addr);
	wire wr_sts = wr && (paddr == irq_status_addr);
	wire wr_msk = wr && (paddr == irq_mask_addr);
	wire addr_ok = (paddr == osc_ctrl_addr) || (paddr == clk_div_addr) ||
		(paddr == unlock_addr) || (paddr == irq_status_addr) ||
		(paddr == irq_mask_addr) || (paddr == pll_timer_addr);
	assign pready = 1'b1;
	assign pslverr = access && !addr_ok;

	// ==========================================================
	// Registers
	logic [2:0] cur_src_r;
	logic [2:0] next_src_r;
	logic switch_r;
	logic sel_freeze_r;
	logic pin_freeze_r;
	logic pll_settled_r;
	logic fail_r;
	logic prim_keep_r;
	logic sec_on_r;
	logic recover_r;
	logic [2:0] ratio_r;
	logic ratio_apply_r;
	logic [2:0] div_src_r;
	logic [1:0] postscale_r;
	logic pll_keep_r;
	logic [1:0] unlock_r;
	logic unlocked_r;
	logic [15:0] pll_timer_r;
	logic [7:0] switch_cnt_r;
	logic [2:0] irq_status_r;
	logic [2:0] irq_mask_r;
	logic boot_load_r;
	logic settled_prev_r;
	logic [31:0] prdata_r;

	// Unlock sequence: two keys back to back open one control write
	wire key1 = wr_unl && (pwdata[15:0] == unlock_key1);
	wire key2 = wr_unl && (pwdata[15:0] == unlock_key2) && unlock_r[0];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_r <= 2'h0;
			unlocked_r <= 1'b0;
		end else begin
			// First key waits for the next write, not the next cycle
			unlock_r <= wr ? {1'b0, key1} : unlock_r;
			unlocked_r <= key2 ? 1'b1 : (wr_osc ? 1'b0 : unlocked_r);
		end
	end
	wire osc_write = wr_osc && unlocked_r;

	// ==========================================================
	// Selection freeze only honoured with monitor enabled
	wire monitor_on = (straps.fail_monitor_cfg == 2'b00);
	wire frozen = monitor_on && sel_freeze_r;
	wire start_switch = osc_write && pwdata[switch_bit] && !frozen;
	wire switch_done = switch_r && (switch_cnt_r == 8'h00);
	wire pin_can_clear = !(straps.one_way_pin_freeze && pin_freeze_r);
	wire pin_nxt = pwdata[pin_freeze_bit] || !pin_can_clear;
	wire pll_active = pll_keep_r || is_pll_src(cur_src_r);
	// Settled status only means something while a PLL source is current
	wire pll_mode = pll_active && is_pll_src(cur_src_r);
	wire timer_out = (pll_timer_r == 16'h0000);

	// Boot source captured in the first clocked cycle after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_load_r <= 1'b1;
			cur_src_r <= 3'h0;
			next_src_r <= 3'h0;
		end else if (boot_load_r) begin
			boot_load_r <= 1'b0;
			cur_src_r <= straps.boot_source_cfg;
			next_src_r <= straps.boot_source_cfg;
		end else begin
			if (switch_done)
				cur_src_r <= next_src_r;
			if (osc_write && !frozen && !switch_r)
				next_src_r <= pwdata[next_src_lsb +: 3];
		end
	end

	// Switch sequencing with a settle count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_r <= 1'b0;
			switch_cnt_r <= 8'h00;
		end else if (start_switch && !switch_r) begin
			switch_r <= 1'b1;
			switch_cnt_r <= 8'(switch_cycles);
		end else if (switch_done) begin
			switch_r <= 1'b0;
		end else if (switch_r) begin
			switch_cnt_r <= switch_cnt_r - 8'h01;
		end
	end

	// Oscillator control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_freeze_r <= 1'b0;
			pin_freeze_r <= 1'b0;
			prim_keep_r <= 1'b0;
			sec_on_r <= 1'b0;
		end else if (osc_write) begin
			sel_freeze_r <= pwdata[sel_freeze_bit] || sel_freeze_r;
			pin_freeze_r <= pin_nxt;
			prim_keep_r <= pwdata[prim_keep_bit];
			sec_on_r <= pwdata[sec_on_bit];
		end
	end

	// Fail flag: set by monitor, cleared by an unlocked write of zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fail_r <= 1'b0;
		else if (clk_fail)
			fail_r <= 1'b1;
		else if (osc_write && !pwdata[fail_bit])
			fail_r <= 1'b0;
	end

	// PLL start-up timer and settled status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_timer_r <= 16'(pll_start_cycles);
			pll_settled_r <= 1'b0;
		end else if (!pll_mode || start_switch || switch_r) begin
			pll_timer_r <= 16'(pll_start_cycles);
			pll_settled_r <= 1'b0;
		end else begin
			if (!timer_out)
				pll_timer_r <= pll_timer_r - 16'h0001;
			pll_settled_r <= pll_locked || timer_out;
		end
	end

	// ==========================================================
	// Clock divider register; interrupt recovery has priority
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recover_r <= 1'b0;
			ratio_r <= ratio_reset;
			ratio_apply_r <= 1'b0;
			div_src_r <= 3'h0;
			postscale_r <= postscale_reset;
			pll_keep_r <= pll_keep_reset;
		end else begin
			if (wr_div) begin
				recover_r <= pwdata[recover_bit];
				ratio_r <= pwdata[ratio_lsb +: 3];
				div_src_r <= pwdata[div_src_lsb +: 3];
				postscale_r <= pwdata[postscale_lsb +: 2];
				pll_keep_r <= pwdata[pll_keep_bit];
			end
			if (recover_r && irq_seen)
				ratio_apply_r <= 1'b0;
			else if (wr_div)
				ratio_apply_r <= pwdata[ratio_apply_bit];
		end
	end

	// ==========================================================
	// Interrupt status: set wins over write-one-to-clear
	wire [2:0] ev = {pll_settled_r && !settled_prev_r, clk_fail, switch_done};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_r <= 3'h0;
			irq_mask_r <= 3'h0;
			settled_prev_r <= 1'b0;
		end else begin
			settled_prev_r <= pll_settled_r;
			irq_status_r <= (irq_status_r & ~(wr_sts ? pwdata[2:0] : 3'h0))
				| ev;
			if (wr_msk)
				irq_mask_r <= pwdata[2:0];
		end
	end
	assign irq = |(irq_status_r & irq_mask_r);

	// ==========================================================
	// Read data
	wire [15:0] osc_view = {1'b0, cur_src_r, 1'b0, next_src_r,
		sel_freeze_r, pin_freeze_r, pll_settled_r, 1'b0, fail_r,
		prim_keep_r, sec_on_r, switch_r};
	wire [15:0] div_view = {recover_r, ratio_r, ratio_apply_r, div_src_r,
		postscale_r, pll_keep_r, 5'h00};
	logic [31:0] rd_nxt;
	always_comb begin
		case (paddr)
			osc_ctrl_addr: rd_nxt = {16'h0000, osc_view};
			clk_div_addr: rd_nxt = {16'h0000, div_view};
			irq_status_addr: rd_nxt = {29'h0, irq_status_r};
			irq_mask_addr: rd_nxt = {29'h0, irq_mask_r};
			pll_timer_addr: rd_nxt = {16'h0000, pll_timer_r};
			default: rd_nxt = 32'h0;
		endcase
	end
	// Read data registered at setup so it stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_r <= 32'h0;
		else if (psel && !penable)
			prdata_r <= rd_nxt;
	end
	assign prdata = prdata_r;

	// ==========================================================
	// Clock steering outputs
	wire [2:0] eff_ratio = ratio_apply_r ? ratio_r : 3'h0;
	assign steer.active_source = cur_src_r;
	assign steer.divider_source = div_src_r;
	assign steer.cpu_ratio = 8'h01 << eff_ratio;
	assign steer.pll_postscale = 4'h1 << postscale_r;
	assign steer.primary_run = !in_sleep || prim_keep_r;
	assign steer.secondary_run = sec_on_r;
	assign steer.pll_run = pll_active;
	assign pin_config_freeze = pin_freeze_r;

endmodule

// ===== verification/osc_select_divider_chk.sv
// Port-level checker for the oscillator select and divider block.
// Assumes the APB byte addresses of osc_ctrl_pkg; bound after endmodule.
`timescale 1ns/1ps
module osc_select_divider_chk
	import osc_ctrl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic cpu_irq,
	input wire logic clock_fail_pin,
	input wire clock_steer_type steer,
	input wire logic pin_config_freeze
);
	// ==========================================================
	// Helper state
	logic [31:0] wd_r;
	logic [7:0] since_r;
	logic [1:0] age_r;
	wire wr = psel && penable && pready && pwrite;
	wire wr_osc = wr && paddr == osc_ctrl_addr;
	wire pll_cur = steer.active_source inside {3'h1, 3'h3};
	// Age hides the strap load; since_r spaces source changes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_r <= 32'h0;
			since_r <= 8'hff;
			age_r <= 2'h0;
		end else begin
			wd_r <= pwdata;
			if ((wr_osc && pwdata[0]) || clock_fail_pin) begin
				since_r <= 8'h0;
			end else if (since_r != 8'hff) begin
				since_r <= since_r + 8'h1;
			end
			if (age_r != 2'h3) begin
				age_r <= age_r + 2'h1;
			end
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Quiet interrupt input so recovery cannot race the write
	sequence s_div_wr;
		wr && paddr == clk_div_addr && !cpu_irq && !$past(cpu_irq)
			&& !$past(cpu_irq, 2) && !$past(cpu_irq, 3);
	endsequence
	sequence s_steady;
		age_r == 2'h3;
	endsequence
	AST_RATIO: assert property (s_div_wr |=>
		steer.cpu_ratio == (wd_r[11] ? 8'h01 << wd_r[14:12] : 8'h01))
		else $error("cpu ratio not taken from divider write");
	AST_POST: assert property (s_div_wr |=>
		steer.pll_postscale == 4'h1 << wd_r[7:6])
		else $error("postscale not taken from divider write");
	AST_DIVSRC: assert property (s_div_wr |=>
		steer.divider_source == wd_r[10:8])
		else $error("divider source not taken from write");
	AST_PLL_OFF: assert property (s_div_wr ##0 !pwdata[5] |=>
		steer.pll_run == pll_cur)
		else $error("pll run wrong with keep bit clear");
	AST_RESET: assert property ($rose(presetn) |->
		steer.cpu_ratio == 8'h01 && steer.pll_postscale == 4'h1
		&& steer.pll_run && !steer.secondary_run && !pin_config_freeze)
		else $error("outputs wrong after reset");
	AST_SRC: assert property (s_steady ##0 $changed(steer.active_source)
		|-> since_r inside {[8'h1:8'h10]})
		else $error("active source changed without a switch");
	AST_SEC: assert property (s_steady ##0 $changed(steer.secondary_run)
		|-> $past(wr_osc))
		else $error("secondary run changed without a write");
	AST_PIN: assert property (s_steady ##0 $changed(pin_config_freeze)
		|-> $past(wr_osc))
		else $error("pin freeze changed without a write");
endmodule

bind osc_select_divider osc_select_divider_chk chk_u (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .cpu_irq(cpu_irq),
	.clock_fail_pin(clock_fail_pin), .steer(steer),
	.pin_config_freeze(pin_config_freeze));

// ===== verification/testbench.sv
// Self-checking bench for the oscillator select and divider block.
// Assumes the design and checker files are compiled before it.
`timescale 1ns/1ps
module testbench;
	import osc_ctrl_pkg::*;
	// ==========================================================
	// Signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd, v;
	logic pready, pslverr, pin_config_freeze, irq;
	logic pll_locked_pin = 1'b0, clock_fail_pin = 1'b0;
	logic sleep_req = 1'b0, cpu_irq = 1'b0;
	logic [31:0] seed = 32'h22c1;
	config_type straps = 6'h11;
	clock_steer_type steer;
	int n_errors = 0, samples_checked = 0;
	always #12.5 pclk = ~pclk;
	osc_select_divider dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .straps(straps),
		.pll_locked_pin(pll_locked_pin), .clock_fail_pin(clock_fail_pin),
		.sleep_req(sleep_req), .cpu_irq(cpu_irq), .steer(steer),
		.pin_config_freeze(pin_config_freeze), .irq(irq));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] nxt(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Expected control word; settled bit follows a PLL source
	function automatic logic [31:0] osc_exp(input logic [2:0] c,
		input logic s, input logic [7:0] x);
		return {17'h0, c, 1'b0, c,
			x | {2'h0, c == 3'h1 || c == 3'h3, 3'h0, s, 1'b0}};
	endfunction
	// Expected one-hot CPU divisor from a divider word
	function automatic logic [7:0] ratio_exp(input logic [31:0] w);
		return w[11] ? 8'h01 << w[14:12] : 8'h01;
	endfunction
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task test_done;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Release, then one idle edge so the next setup lands on a fresh step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task unlock;
		apb(1'b1, unlock_addr, unlock_key1);
		apb(1'b1, unlock_addr, unlock_key2);
	endtask
	task rst(input logic [5:0] cfg);
		presetn <= 1'b0;
		straps <= cfg;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	task pulse;
		cpu_irq <= 1'b1;
		repeat (3) @(posedge pclk);
		cpu_irq <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	// Switch, poll the busy bit within a bound, then compare
	task sw(input logic [2:0] c, input logic s, input logic [7:0] x);
		int k;
		unlock();
		apb(1'b1, osc_ctrl_addr, {21'h0, c, x | {6'h0, s, 1'b1}});
		apb(1'b0, osc_ctrl_addr, 32'h0);
		chk("busy", rd[0], 1'b1);
		k = 0;
		while (rd[0] && k < 20) begin
			apb(1'b0, osc_ctrl_addr, 32'h0);
			k++;
		end
		if (c == 3'h1 || c == 3'h3) repeat (100) @(posedge pclk);
		apb(1'b0, osc_ctrl_addr, 32'h0);
		chk("osc", rd, osc_exp(c, s, x));
		chk("src", steer.active_source, c);
		chk("sec", steer.secondary_run, s);
	endtask
	// ==========================================================
	// Watchdog
	initial begin
		#(40000 * 25);
		n_errors++;
		test_done();
	end
	// ==========================================================
	// Main sequence
	initial begin
		@(posedge pclk);
		rst(6'h11);
		apb(1'b0, clk_div_addr, 32'h0);
		chk("div", rd, 32'h3020);
		apb(1'b0, osc_ctrl_addr, 32'h0);
		chk("osc", rd, osc_exp(3'h2, 1'b0, 8'h0));
		chk("src", steer.active_source, 3'h2);
		apb(1'b0, 8'h04, 32'h0);
		chk("err", er, 1'b1);
		chk("unm", rd, 32'h0);
		apb(1'b1, osc_ctrl_addr, 32'h0303);
		apb(1'b0, osc_ctrl_addr, 32'h0);
		chk("lock", rd, osc_exp(3'h2, 1'b0, 8'h0));
		for (int k = 0; k < 8; k++) begin
			seed = nxt(seed);
			if (k != 6) sw(3'(k), seed[4], 8'h0);
		end
		// Interrupt: masked, unmasked, then cleared by writing ones
		chk("irq", irq, 1'b0);
		apb(1'b1, irq_mask_addr, 32'h7);
		chk("irq", irq, 1'b1);
		apb(1'b1, irq_status_addr, 32'h7);
		chk("irq", irq, 1'b0);
		for (int i = 0; i < 16; i++) begin
			seed = nxt(seed);
			v = (i == 0) ? 32'h79c0 : seed & 32'h7fe0;
			if (v[10:8] == 3'h7) v[10:8] = 3'h0;
			apb(1'b1, clk_div_addr, v);
			apb(1'b0, clk_div_addr, 32'h0);
			chk("div", rd, v);
			chk("ratio", steer.cpu_ratio, ratio_exp(v));
			chk("post", steer.pll_postscale, 4'h1 << v[7:6]);
			chk("dsrc", steer.divider_source, v[10:8]);
			chk("pll", steer.pll_run, v[5]);
		end
		apb(1'b1, clk_div_addr, 32'hd800);
		chk("ratio", steer.cpu_ratio, 8'h20);
		pulse();
		apb(1'b0, clk_div_addr, 32'h0);
		chk("rec", rd[11], 1'b0);
		chk("ratio", steer.cpu_ratio, 8'h01);
		apb(1'b1, clk_div_addr, 32'h5800);
		pulse();
		apb(1'b0, clk_div_addr, 32'h0);
		chk("hold", rd, 32'h5800);
		// Frozen selection with the monitor enabled
		unlock();
		apb(1'b1, osc_ctrl_addr, 32'h0780);
		unlock();
		apb(1'b1, osc_ctrl_addr, 32'h0201);
		repeat (10) @(posedge pclk);
		apb(1'b0, osc_ctrl_addr, 32'h0);
		chk("next", rd[10:8], 3'h7);
		chk("src", steer.active_source, 3'h7);
		unlock();
		apb(1'b1, osc_ctrl_addr, 32'h0740);
		chk("pin", pin_config_freeze, 1'b1);
		unlock();
		apb(1'b1, osc_ctrl_addr, 32'h0700);
		chk("pin", pin_config_freeze, 1'b1);
		// Second run: monitor off, pin freeze two-way
		rst(6'h04);
		chk("src", steer.active_source, 3'h0);
		unlock();
		apb(1'b1, osc_ctrl_addr, 32'h0080);
		sw(3'h2, 1'b0, 8'h80);
		sleep_req <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("prim", steer.primary_run, 1'b0);
		unlock();
		apb(1'b1, osc_ctrl_addr, 32'h0284);
		chk("prim", steer.primary_run, 1'b1);
		sleep_req <= 1'b0;
		apb(1'b1, osc_ctrl_addr, 32'h02c0);
		chk("pin", pin_config_freeze, 1'b0);
		unlock();
		apb(1'b1, osc_ctrl_addr, 32'h02c0);
		chk("pin", pin_config_freeze, 1'b1);
		unlock();
		apb(1'b1, osc_ctrl_addr, 32'h0280);
		chk("pin", pin_config_freeze, 1'b0);
		// Lock pin settles the PLL long before the start-up timer runs out
		pll_locked_pin <= 1'b1;
		unlock();
		apb(1'b1, osc_ctrl_addr, 32'h0381);
		repeat (12) @(posedge pclk);
		apb(1'b0, osc_ctrl_addr, 32'h0);
		chk("lock", rd[5], 1'b1);
		chk("src", steer.active_source, 3'h3);
		clock_fail_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		clock_fail_pin <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, osc_ctrl_addr, 32'h0);
		chk("fail", rd[3], 1'b1);
		apb(1'b0, irq_status_addr, 32'h0);
		chk("fst", rd[1], 1'b1);
		chk("pst", rd[2], 1'b1);
		test_done();
	end
endmodule
